// *** logic/kbd_emul.v ***
// Keyboard controller emulation: EC/host message interface with host and EC interrupts.
// Assumes host and EC strobes are one-cycle pulses on clk; tick_1mhz comes from another domain.
`include "kbd_emul_map.vh"

module kbd_emul #(
    parameter RST_PULSE_US = `KE_RST_PULSE_US
) (
    // Clock and reset
    input  wire        clk,
    input  wire        resetn,
    // EC register port
    input  wire [11:0] ec_addr,
    input  wire        ec_wr,
    input  wire        ec_rd,
    input  wire [7:0]  ec_wdata,
    output reg  [7:0]  ec_rdata,
    // Host I/O port
    input  wire        host_data_wr,
    input  wire        host_cmd_wr,
    input  wire        host_data_rd,
    input  wire        host_stat_rd,
    input  wire [7:0]  host_wdata,
    output reg  [7:0]  host_rdata,
    // 1 MHz timebase
    input  wire        tick_1mhz,
    // Interrupts and reset
    output wire        kbd_host_irq,
    output wire        aux_host_irq,
    output reg         in_buffer_full_irq,
    output reg         out_buffer_empty_irq,
    output wire        kbd_reset_out
);

    reg        activate_r;
    reg  [2:0] control_r;
    reg  [7:0] out_data_r;
    reg  [7:0] in_data_r;
    reg        out_buffer_full_r;
    reg        in_buffer_full_r;
    reg        cmd_r;
    reg        kbd_hw_r;
    reg        kbd_fw_r;
    reg        aux_hw_r;
    reg        aux_fw_r;
    reg        tick_s1_r;
    reg        tick_s2_r;
    reg        tick_s3_r;
    reg        rst_busy_r;
    reg  [7:0] rst_cnt_r;

    wire host_irq_gate          = control_r[`KE_CT_GATE];
    wire kbd_flag_fw_select     = control_r[`KE_CT_KBD_SEL];
    wire aux_flag_source_select = control_r[`KE_CT_AUX_SEL];

    // Host traffic, EC writes and EC main-data reads only count while the interface is active; the activate write always counts
    wire h_wr       = activate_r & (host_data_wr | host_cmd_wr);
    wire h_rd       = activate_r & host_data_rd;
    wire e_wr       = activate_r & ec_wr;
    wire wr_main    = e_wr & (ec_addr == `KE_OFF_MAIN_DATA);
    wire wr_aux     = e_wr & (ec_addr == `KE_OFF_AUX_DATA);
    wire wr_status  = e_wr & (ec_addr == `KE_OFF_STATUS);
    wire wr_control = e_wr & (ec_addr == `KE_OFF_CONTROL);
    wire wr_kflag   = e_wr & (ec_addr == `KE_OFF_KBD_FLAG);
    wire rd_in_data = activate_r & ec_rd & (ec_addr == `KE_OFF_MAIN_DATA);

    wire kbd_out_flag = kbd_flag_fw_select ? kbd_fw_r : kbd_hw_r;
    wire aux_out_flag = aux_flag_source_select ? aux_fw_r : aux_hw_r;

    assign kbd_host_irq = activate_r & host_irq_gate & kbd_out_flag;
    assign aux_host_irq = activate_r & host_irq_gate & aux_out_flag;

    wire [7:0] status_w = {2'b00, aux_out_flag, 1'b0, cmd_r, 1'b0,
                           in_buffer_full_r, out_buffer_full_r};

    wire out_full_nxt = (wr_main | wr_aux) ? 1'b1 : (h_rd ? 1'b0 : out_buffer_full_r);
    wire in_full_nxt  = h_wr ? 1'b1 : (rd_in_data ? 1'b0 : in_buffer_full_r);

    // Data and flags; set wins over a clear in the same cycle
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            activate_r        <= 1'b0;
            control_r         <= `KE_CONTROL_RST;
            out_data_r        <= `KE_BYTE_RST;
            in_data_r         <= `KE_BYTE_RST;
            out_buffer_full_r <= 1'b0;
            in_buffer_full_r  <= 1'b0;
            cmd_r             <= 1'b0;
            kbd_hw_r          <= 1'b0;
            kbd_fw_r          <= 1'b0;
            aux_hw_r          <= 1'b0;
            aux_fw_r          <= 1'b0;
            in_buffer_full_irq   <= 1'b0;
            out_buffer_empty_irq <= 1'b0;
        end
        else
        begin
            if (ec_wr && ec_addr == `KE_OFF_ACTIVATE)
                activate_r <= ec_wdata[0];
            if (!activate_r)
            begin
                // Powered down: buffer, hardware and irq flags clear; cmd_r, kbd_fw_r and aux_fw_r keep their value
                out_buffer_full_r <= 1'b0;
                in_buffer_full_r  <= 1'b0;
                kbd_hw_r          <= 1'b0;
                aux_hw_r          <= 1'b0;
                in_buffer_full_irq   <= 1'b0;
                out_buffer_empty_irq <= 1'b0;
            end
            else
            begin
                if (wr_control)
                    control_r <= ec_wdata[2:0];
                if (wr_main | wr_aux)
                    out_data_r <= ec_wdata;
                if (h_wr)
                begin
                    in_data_r <= host_wdata;
                    cmd_r     <= host_cmd_wr;
                end
                out_buffer_full_r <= out_full_nxt;
                in_buffer_full_r  <= in_full_nxt;
                if (wr_main)
                    kbd_hw_r <= 1'b1;
                else if (h_rd)
                    kbd_hw_r <= 1'b0;
                if (wr_aux)
                    aux_hw_r <= 1'b1;
                else if (h_rd)
                    aux_hw_r <= 1'b0;
                if (wr_kflag)
                    kbd_fw_r <= ec_wdata[0];
                if (wr_status)
                    aux_fw_r <= ec_wdata[`KE_ST_AUX];
                in_buffer_full_irq   <= in_full_nxt & ~in_buffer_full_r;
                out_buffer_empty_irq <= ~out_full_nxt & out_buffer_full_r;
            end
        end
    end

    // EC read mux, combinational then registered a cycle later
    reg [7:0] ec_rdata_nxt;
    always @*
    begin
        ec_rdata_nxt = 8'h00;
        if (ec_addr == `KE_OFF_MAIN_DATA)
            ec_rdata_nxt = in_data_r;
        else if (ec_addr == `KE_OFF_STATUS)
            ec_rdata_nxt = status_w;
        else if (ec_addr == `KE_OFF_CONTROL)
            ec_rdata_nxt = {5'h00, control_r};
        else if (ec_addr == `KE_OFF_KBD_FLAG)
            ec_rdata_nxt = {7'h00, kbd_out_flag};
        else if (ec_addr == `KE_OFF_ACTIVATE)
            ec_rdata_nxt = {7'h00, activate_r};
    end

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ec_rdata   <= `KE_BYTE_RST;
            host_rdata <= `KE_BYTE_RST;
        end
        else
        begin
            if (ec_rd)
                ec_rdata <= ec_rdata_nxt;
            if (h_rd)
                host_rdata <= out_data_r;
            else if (activate_r && host_stat_rd)
                host_rdata <= status_w;
        end
    end

    // CPU reset pulse timed by 1 MHz rising edges; slow clock is asynchronous to clk
    wire tick_rise = tick_s2_r & ~tick_s3_r;
    wire rst_start = activate_r & host_cmd_wr & (host_wdata == `KE_CMD_CPU_RESET);

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tick_s1_r  <= 1'b0;
            tick_s2_r  <= 1'b0;
            tick_s3_r  <= 1'b0;
            rst_busy_r <= 1'b0;
            rst_cnt_r  <= 8'h00;
        end
        else
        begin
            tick_s1_r <= tick_1mhz;
            tick_s2_r <= tick_s1_r;
            tick_s3_r <= tick_s2_r;
            if (!activate_r)
                rst_busy_r <= 1'b0;
            else if (rst_start && !rst_busy_r)
            begin
                rst_busy_r <= 1'b1;
                rst_cnt_r  <= 8'h00;
            end
            else if (rst_busy_r && tick_rise)
            begin
                if (rst_cnt_r == RST_PULSE_US[7:0] - 8'h01)
                    rst_busy_r <= 1'b0;
                rst_cnt_r <= rst_cnt_r + 8'h01;
            end
        end
    end

    assign kbd_reset_out = rst_busy_r;

endmodule

// *** logic/kbd_emul_map.vh ***
// Offsets, field positions, reset values and timing for the keyboard emulation block.
// Included by the block's design file only.
`ifndef KBD_EMUL_MAP_VH
`define KBD_EMUL_MAP_VH

// EC-side register offsets
`define KE_OFF_MAIN_DATA   12'h000
`define KE_OFF_STATUS      12'h004
`define KE_OFF_CONTROL     12'h008
`define KE_OFF_AUX_DATA    12'h00C
`define KE_OFF_KBD_FLAG    12'h010
`define KE_OFF_ACTIVATE    12'h330

// Status register fields
`define KE_ST_OUT_FULL     0
`define KE_ST_IN_FULL      1
`define KE_ST_CMD          3
`define KE_ST_AUX          5

// Control register fields
`define KE_CT_GATE         0
`define KE_CT_KBD_SEL      1
`define KE_CT_AUX_SEL      2

// Reset values
`define KE_CONTROL_RST     3'h0
`define KE_BYTE_RST        8'h00

// Host command that starts a CPU reset pulse
`define KE_CMD_CPU_RESET   8'hFE

// CPU reset pulse length in 1 MHz ticks
`define KE_RST_PULSE_US    6

`endif

// *** test/kbd_emul_sva.sv ***
// Port checker for the keyboard emulation block.
// Assumes one-cycle strobes on clk; bound to every kbd_emul instance.
module kbd_emul_sva (
    // Clock and reset
    input logic        clk,
    input logic        resetn,
    // EC and host strobes, host write data
    input logic        ec_wr,
    input logic        host_data_wr,
    input logic        host_cmd_wr,
    input logic        host_data_rd,
    input logic [7:0]  host_wdata,
    // Outputs watched
    input logic        kbd_host_irq,
    input logic        aux_host_irq,
    input logic        in_buffer_full_irq,
    input logic        out_buffer_empty_irq,
    input logic        kbd_reset_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    kbd_irq_rise_a: assert property (
        $rose(kbd_host_irq) |-> $past(ec_wr))
        else $error("kbd irq rose without EC write");
    aux_irq_rise_a: assert property (
        $rose(aux_host_irq) |-> $past(ec_wr))
        else $error("aux irq rose without EC write");
    kbd_irq_fall_a: assert property (
        $fell(kbd_host_irq) |-> $past(ec_wr || host_data_rd))
        else $error("kbd irq fell without cause");
    aux_irq_fall_a: assert property (
        $fell(aux_host_irq) |-> $past(ec_wr || host_data_rd))
        else $error("aux irq fell without cause");
    full_cause_a: assert property (
        in_buffer_full_irq |-> $past(host_data_wr || host_cmd_wr))
        else $error("input-full irq without host write");
    full_pulse_a: assert property (
        in_buffer_full_irq |=> !in_buffer_full_irq)
        else $error("input-full irq longer than a cycle");
    empty_cause_a: assert property (
        out_buffer_empty_irq |-> $past(host_data_rd))
        else $error("output-empty irq without host read");
    empty_pulse_a: assert property (
        out_buffer_empty_irq |=> !out_buffer_empty_irq)
        else $error("output-empty irq longer than a cycle");
    rst_cause_a: assert property (
        $rose(kbd_reset_out) |-> $past(host_cmd_wr && host_wdata == 8'hFE))
        else $error("reset pulse without command");
    cover property (in_buffer_full_irq);
    cover property (out_buffer_empty_irq);
    cover property ($fell(kbd_reset_out));
endmodule

bind kbd_emul kbd_emul_sva u_kbd_emul_sva (.clk, .resetn, .ec_wr, .host_data_wr, .host_cmd_wr,
    .host_data_rd, .host_wdata, .kbd_host_irq, .aux_host_irq, .in_buffer_full_irq,
    .out_buffer_empty_irq, .kbd_reset_out);

// *** test/host_model.sv ***
// Host side model: one I/O strobe per call, changed only after a clock edge.
// Assumes the block takes each strobe at the next rising edge.
module host_model (
    // Clock
    input  logic       clk,
    // Host I/O strobes and data
    output logic       host_data_wr,
    output logic       host_cmd_wr,
    output logic       host_data_rd,
    output logic       host_stat_rd,
    output logic [7:0] host_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {host_data_wr, host_cmd_wr, host_data_rd, host_stat_rd, host_wdata} = '0;
    // Irqs taken as IRQ1 and IRQ12 by the host; no routing here
    task automatic io(input int kind, input logic [7:0] v);
        @(posedge clk);
        host_wdata <= v;
        {host_data_wr, host_cmd_wr, host_data_rd, host_stat_rd} <= 4'h8 >> kind;
        @(posedge clk);
        {host_data_wr, host_cmd_wr, host_data_rd, host_stat_rd} <= 4'h0;
        // Bus released: never leave the old byte showing
        host_wdata <= ~v;
        #1;
    endtask
endmodule

// *** test/test_kbd_emul.sv ***
// Self-checking bench for the keyboard emulation block.
// Drives the EC port itself and the host port through the host model.
module test_kbd_emul;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0;
    logic        resetn = 0;
    logic        tick_1mhz = 0;
    logic [11:0] ec_addr = 12'h000;
    logic        ec_wr = 0;
    logic        ec_rd = 0;
    logic [7:0]  ec_wdata = 8'h00;
    logic [7:0]  d, v;
    wire  [7:0]  ec_rdata, host_rdata, host_wdata;
    wire         host_data_wr, host_cmd_wr, host_data_rd, host_stat_rd, kbd_reset_out;
    wire         kbd_host_irq, aux_host_irq, in_buffer_full_irq, out_buffer_empty_irq;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          n;
    kbd_emul #(.RST_PULSE_US(2)) u_kbd_emul (.clk, .resetn, .ec_addr, .ec_wr, .ec_rd,
        .ec_wdata, .ec_rdata, .host_data_wr, .host_cmd_wr, .host_data_rd, .host_stat_rd,
        .host_wdata, .host_rdata, .tick_1mhz, .kbd_host_irq, .aux_host_irq,
        .in_buffer_full_irq, .out_buffer_empty_irq, .kbd_reset_out);
    host_model host (.clk, .host_data_wr, .host_cmd_wr, .host_data_rd, .host_stat_rd,
        .host_wdata);
    initial forever #4 clk = ~clk;
    initial forever #500 tick_1mhz = ~tick_1mhz;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic ec(input logic wr, input logic [11:0] a, input logic [7:0] w);
        @(posedge clk);
        {ec_wr, ec_rd, ec_addr, ec_wdata} <= {wr, !wr, a, w};
        @(posedge clk);
        {ec_wr, ec_rd, ec_wdata} <= {2'h0, ~w};
        #1;
        v = ec_rdata;
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        n = $urandom(69);
        repeat (3) @(posedge clk);
        resetn <= 1;
        ec(1, 12'h330, 8'h01);
        ec(0, 12'h010, 8'h00);
        chk(v, 8'h00);
        ec(0, 12'h004, 8'h00);
        chk(v, 8'h00);
        ec(0, 12'h0FC, 8'h00);
        chk(v, 8'h00);
        ec(1, 12'h008, 8'h01);
        $display("reset values done");
        for (int i = 0; i < 6; i++)
        begin
            d = (i == 0) ? 8'hFF : 8'($urandom);
            ec(1, i[0] ? 12'h00C : 12'h000, d);
            chk({kbd_host_irq, aux_host_irq}, i[0] ? 8'h01 : 8'h02);
            ec(0, 12'h004, 8'h00);
            chk(v[0], 8'h01);
            ec(0, 12'h010, 8'h00);
            chk(v[0], !i[0]);
            host.io(2, 8'h00);
            chk(host_rdata, d);
            chk(out_buffer_empty_irq, 8'h01);
            chk({kbd_host_irq, aux_host_irq}, 8'h00);
        end
        $display("data path done");
        ec(1, 12'h008, 8'h00);
        ec(1, 12'h000, 8'h5A);
        chk(kbd_host_irq, 8'h00);
        host.io(2, 8'h00);
        ec(1, 12'h008, 8'h03);
        ec(1, 12'h010, 8'h01);
        host.io(2, 8'h00);
        chk(kbd_host_irq, 8'h01);
        ec(1, 12'h010, 8'h00);
        chk(kbd_host_irq, 8'h00);
        ec(1, 12'h008, 8'h05);
        ec(1, 12'h004, 8'h20);
        chk(aux_host_irq, 8'h01);
        ec(1, 12'h004, 8'h00);
        chk(aux_host_irq, 8'h00);
        $display("gate and firmware done");
        d = 8'($urandom);
        host.io(0, d);
        chk(in_buffer_full_irq, 8'h01);
        host.io(3, 8'h00);
        chk(host_rdata, 8'h02);
        ec(0, 12'h000, 8'h00);
        chk(v, d);
        host.io(1, 8'hFE);
        chk(kbd_reset_out, 8'h01);
        // Sample a settled output, not in the edge's own time step
        for (n = 0; kbd_reset_out === 1'b1 && n < 1000; n++)
        begin
            @(posedge clk);
            #1;
        end
        chk(n inside {[125:252]}, 8'h01);
        $display("host writes done");
        ec(1, 12'h330, 8'h00);
        ec(1, 12'h008, 8'h01);
        ec(1, 12'h000, d);
        host.io(0, d);
        chk({in_buffer_full_irq, kbd_host_irq}, 8'h00);
        ec(0, 12'h008, 8'h00);
        chk(v, 8'h05);
        $display("inactive done");
        test_done();
    end
    initial
    begin
        #50000;
        error_cnt++;
        test_done();
    end
endmodule
